// ==== hdl/pdstc_pkg.sv ====
// package for the power-down and self-test pin control block
// assumes a single 200 MHz core clock and a plain register port
package pdstc_pkg;
   // register offsets
   localparam logic [3:0] PDSTC_ADDR_CTRL   = 4'h0;
   localparam logic [3:0] PDSTC_ADDR_STATUS = 4'h1;
   // control register field positions
   localparam int PDSTC_CTRL_PIN4_BIST_BIT = 0;
   localparam int PDSTC_CTRL_PIN16_IO_BIT  = 1;
   localparam int PDSTC_CTRL_GPIO3_OE_BIT  = 2;
   localparam int PDSTC_CTRL_GPIO3_OUT_BIT = 3;
   localparam int PDSTC_CTRL_INT_PULL_BIT  = 4;
   localparam int PDSTC_CTRL_W             = 5;
   // status word carries the one-hot power state in its low bits
   localparam int PDSTC_STATUS_W           = 3;
   localparam logic [4:0] PDSTC_CTRL_RESET = 5'h00;
   localparam logic [31:0] PDSTC_ZERO32    = 32'h0000_0000;
   // self-test clock choice
   localparam logic PDSTC_BCLK_PIXEL = 1'b0;
   localparam logic PDSTC_BCLK_OSC   = 1'b1;
   // power states, one-hot
   typedef enum logic [2:0] {
      PDSTC_ST_DOWN  = 3'b001,
      PDSTC_ST_RESET = 3'b010,
      PDSTC_ST_RUN   = 3'b100
   } pdstc_state_t;
endpackage : pdstc_pkg

// ==== hdl/pdstc_top.sv ====
// control-pin logic: power-down input, self-test enable and clock select,
// shared interrupt/clock-select pin and shared peripheral-select/gpio pin
// assumes pins are synchronous to I_CORE_CLK; pad pulldowns are modelled here
`timescale 1ns/1ps
// Functional notes
// - power-down release enables and resets all state
// - low power-down input keeps device powered down
// - powered down: cmos outputs tristated, pll stopped
// - undriven power-down input reads low
// - self-test enable pin: 0 off, 1 on
// - shared pin is interrupt input by default
// - interrupt pin may pull low while down
// - register picks spi select or fast gpio 3
module pdstc_top
   import pdstc_pkg::*;
(
   // clock and reset
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RST,
   // power-down pin; the driven flag is high when the host drives it
   input  wire logic        I_POWER_DOWN_N,
   input  wire logic        I_POWER_DOWN_N_DRIVEN,
   // self-test pins
   input  wire logic        I_SELF_TEST_ENABLE_PIN,
   input  wire logic        I_PIN4,
   // shared pin 16
   input  wire logic        I_PIN16,
   input  wire logic        I_SPI_SELECT_DRIVE,
   // register port
   input  wire logic [3:0]  I_ADDR,
   input  wire logic [31:0] I_WDATA,
   input  wire logic        I_WR,
   input  wire logic        I_RD,
   output logic      [31:0] O_RDATA,
   // pin 4 driver (interrupt pin)
   output logic             O_PIN4,
   output logic             O_PIN4_OE,
   // pin 16 driver
   output logic             O_PIN16,
   output logic             O_PIN16_OE,
   // functional outputs
   output logic             O_DEVICE_ENABLED,
   output logic             O_CORE_RESET,
   output logic             O_PLL_RUN,
   output logic             O_CMOS_OE,
   output logic             O_SELF_TEST_ON,
   output logic             O_SELF_TEST_CLK_SEL,
   output logic             O_INTERRUPT_IN,
   output logic             O_SPI_SELECT,
   output logic             O_FAST_GPIO_3_IN
);

   // address decode shared by the write and read paths
   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] target);
      reg_hit = (addr == target);
   endfunction : reg_hit

   // one-hot state code as it appears in the status word
   function automatic logic [PDSTC_STATUS_W-1:0] state_code(input pdstc_state_t st);
      state_code = PDSTC_STATUS_W'(st);
   endfunction : state_code

   // effective pad level of the power-down input
   // an undriven pad falls to its weak pulldown, so a host that has not
   // yet taken the pin keeps the device powered down
   logic power_down_n;
   assign power_down_n = I_POWER_DOWN_N_DRIVEN & I_POWER_DOWN_N;

   // power state machine
   // release passes through a one-cycle reset state so that every register
   // sees a clean clear before the register port opens again
   pdstc_state_t state_q, state_d;
   always_comb begin
      state_d = state_q;
      case (state_q)
         PDSTC_ST_DOWN: begin
            if (power_down_n) begin
               state_d = PDSTC_ST_RESET;
            end
         end
         PDSTC_ST_RESET: begin
            if (power_down_n) begin
               state_d = PDSTC_ST_RUN;
            end else begin
               state_d = PDSTC_ST_DOWN;
            end
         end
         PDSTC_ST_RUN: begin
            if (!power_down_n) begin
               state_d = PDSTC_ST_DOWN;
            end
         end
         default: begin
            state_d = PDSTC_ST_DOWN;
         end
      endcase
   end

   // state register; the core reset parks the machine powered down
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         state_q <= PDSTC_ST_DOWN;
      end else begin
         state_q <= state_d;
      end
   end

   // run and down qualifiers shared by the functional outputs
   logic running;
   logic in_down;
   assign running = (state_q == PDSTC_ST_RUN);
   assign in_down = (state_q == PDSTC_ST_DOWN);

   // control register next value
   // writes land only in the run state; outside it the register is held at
   // its default so the release always starts from a known configuration
   logic [PDSTC_CTRL_W-1:0] ctrl_q, ctrl_d;
   logic                    ctrl_wr;
   assign ctrl_wr = I_WR & reg_hit(I_ADDR, PDSTC_ADDR_CTRL);
   always_comb begin
      ctrl_d = ctrl_q;
      if (!running) begin
         ctrl_d = PDSTC_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_d = I_WDATA[PDSTC_CTRL_W-1:0];
      end
   end

   // control register
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         ctrl_q <= PDSTC_CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // decoded pin functions
   logic pin4_is_bist;
   logic pin16_is_io;
   logic gpio3_oe;
   logic gpio3_out;
   assign pin4_is_bist = ctrl_q[PDSTC_CTRL_PIN4_BIST_BIT];
   assign pin16_is_io  = ctrl_q[PDSTC_CTRL_PIN16_IO_BIT];
   assign gpio3_oe     = ctrl_q[PDSTC_CTRL_GPIO3_OE_BIT];
   assign gpio3_out    = ctrl_q[PDSTC_CTRL_GPIO3_OUT_BIT];

   // interrupt pull-low request next value
   // the control register clears as soon as the run state ends, so the
   // request is copied here while running and held through power-down;
   // the reset state clears it like any other register
   logic pull_q, pull_d;
   always_comb begin
      pull_d = pull_q;
      case (state_q)
         PDSTC_ST_RUN: begin
            pull_d = ctrl_q[PDSTC_CTRL_INT_PULL_BIT];
         end
         PDSTC_ST_RESET: begin
            pull_d = 1'h0;
         end
         PDSTC_ST_DOWN: begin
            pull_d = pull_q;
         end
         default: begin
            pull_d = 1'h0;
         end
      endcase
   end

   // interrupt pull-low request register
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         pull_q <= 1'h0;
      end else begin
         pull_q <= pull_d;
      end
   end

   // power outputs next value; all follow the run state
   logic en_d, rst_d, pll_d, cmos_d;
   always_comb begin
      en_d   = running;
      rst_d  = ~running;
      pll_d  = running;
      cmos_d = running;
   end

   // power outputs; powered down after the core reset
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_DEVICE_ENABLED <= 1'h0;
         O_CORE_RESET     <= 1'h1;
         O_PLL_RUN        <= 1'h0;
         O_CMOS_OE        <= 1'h0;
      end else begin
         O_DEVICE_ENABLED <= en_d;
         O_CORE_RESET     <= rst_d;
         O_PLL_RUN        <= pll_d;
         O_CMOS_OE        <= cmos_d;
      end
   end

   // self-test outputs next value
   // the clock select level is only honoured while the shared pin is in
   // clock-select mode; as an interrupt input it leaves the pixel clock
   logic st_d, clk_d;
   always_comb begin
      st_d  = running & I_SELF_TEST_ENABLE_PIN;
      clk_d = PDSTC_BCLK_PIXEL;
      if (running && pin4_is_bist && I_PIN4) begin
         clk_d = PDSTC_BCLK_OSC;
      end else begin
         clk_d = PDSTC_BCLK_PIXEL;
      end
   end

   // self-test outputs
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_SELF_TEST_ON      <= 1'h0;
         O_SELF_TEST_CLK_SEL <= PDSTC_BCLK_PIXEL;
      end else begin
         O_SELF_TEST_ON      <= st_d;
         O_SELF_TEST_CLK_SEL <= clk_d;
      end
   end

   // shared pin input functions next value
   // while running each shared pin feeds exactly one function and the other reads low; all read low when not running
   logic int_d, cs_d, g3_d;
   always_comb begin
      int_d = running & ~pin4_is_bist & I_PIN4;
      cs_d  = running & ~pin16_is_io & I_PIN16;
      g3_d  = running & pin16_is_io & I_PIN16;
   end

   // shared pin input functions
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_INTERRUPT_IN   <= 1'h0;
         O_SPI_SELECT     <= 1'h0;
         O_FAST_GPIO_3_IN <= 1'h0;
      end else begin
         O_INTERRUPT_IN   <= int_d;
         O_SPI_SELECT     <= cs_d;
         O_FAST_GPIO_3_IN <= g3_d;
      end
   end

   // pad drivers next value
   // pin 4 is only ever pulled low, never driven high, and only while the
   // device is down; the gpio 3 driver is released whenever not running
   logic p4_d, p4oe_d, p16_d, p16oe_d;
   always_comb begin
      p4_d    = 1'h0;
      p4oe_d  = in_down & pull_q;
      p16_d   = running & gpio3_out;
      p16oe_d = running & pin16_is_io & gpio3_oe;
   end

   // pad drivers
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_PIN4     <= 1'h0;
         O_PIN4_OE  <= 1'h0;
         O_PIN16    <= 1'h0;
         O_PIN16_OE <= 1'h0;
      end else begin
         O_PIN4     <= p4_d;
         O_PIN4_OE  <= p4oe_d;
         O_PIN16    <= p16_d;
         O_PIN16_OE <= p16oe_d;
      end
   end

   // read data next value
   // read data stand for the one cycle after the strobe and are zero
   // otherwise; unmapped offsets read as zero
   logic [31:0] rdata_d;
   always_comb begin
      rdata_d = PDSTC_ZERO32;
      if (I_RD) begin
         if (reg_hit(I_ADDR, PDSTC_ADDR_CTRL)) begin
            rdata_d[PDSTC_CTRL_W-1:0] = ctrl_q;
         end else if (reg_hit(I_ADDR, PDSTC_ADDR_STATUS)) begin
            rdata_d[PDSTC_STATUS_W-1:0] = state_code(state_q);
         end else begin
            rdata_d = PDSTC_ZERO32;
         end
      end
   end

   // read data register
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_RDATA <= PDSTC_ZERO32;
      end else begin
         O_RDATA <= rdata_d;
      end
   end

endmodule : pdstc_top

// ==== tb/pdstc_chk.sv ====
// assertions on the pin control block ports
// bound to pdstc_top; one clock, sync reset
`timescale 1ns/1ps
module pdstc_chk (
   // clock, reset and pins
   input wire logic I_CORE_CLK, I_RST, I_POWER_DOWN_N, I_POWER_DOWN_N_DRIVEN,
   input wire logic I_SELF_TEST_ENABLE_PIN, I_PIN4,
   // outputs watched
   input wire logic O_DEVICE_ENABLED, O_CORE_RESET, O_PLL_RUN, O_CMOS_OE, O_PIN16_OE,
   input wire logic O_SELF_TEST_ON, O_SELF_TEST_CLK_SEL, O_INTERRUPT_IN, O_PIN4_OE, O_PIN4,
   input wire logic O_SPI_SELECT, O_FAST_GPIO_3_IN
);
   logic pd;
   // undriven pin reads low
   assign pd = I_POWER_DOWN_N & I_POWER_DOWN_N_DRIVEN;
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);
   a_up_runs: assert property (pd [*3] |=> O_DEVICE_ENABLED && O_PLL_RUN)
      else $error("not running");
   a_down_held: assert property (!pd [*2] |=> !O_DEVICE_ENABLED && O_CORE_RESET)
      else $error("not down");
   a_down_tri: assert property (!pd [*2] |=> !O_CMOS_OE && !O_PLL_RUN && !O_PIN16_OE)
      else $error("outputs on");
   a_bist_follow: assert property (O_DEVICE_ENABLED && $past(O_DEVICE_ENABLED) &&
      $stable(I_SELF_TEST_ENABLE_PIN) |-> O_SELF_TEST_ON == I_SELF_TEST_ENABLE_PIN)
      else $error("bist");
   a_csel_pin: assert property (O_SELF_TEST_CLK_SEL && $stable(I_PIN4) |-> I_PIN4)
      else $error("clk sel");
   a_pull_low: assert property (O_PIN4_OE |-> !O_DEVICE_ENABLED && !O_PIN4)
      else $error("pull");
   a_pin16_one: assert property (!(O_SPI_SELECT && O_FAST_GPIO_3_IN))
      else $error("pin16");
   a_int_ignores: assert property (O_INTERRUPT_IN |-> !O_SELF_TEST_CLK_SEL)
      else $error("int");
endmodule : pdstc_chk

// ==== tb/pdstc_host.sv ====
// host model driving the control pins
// pins change by nba after a rising edge
`timescale 1ns/1ps
module pdstc_host (
   input  wire logic I_CORE_CLK,
   output logic      I_POWER_DOWN_N_DRIVEN, I_POWER_DOWN_N, I_SELF_TEST_ENABLE_PIN,
   output logic      I_PIN4, I_PIN16
);
   // power-down held low until supplies good
   initial {I_POWER_DOWN_N_DRIVEN, I_POWER_DOWN_N, I_SELF_TEST_ENABLE_PIN, I_PIN4, I_PIN16} = 5'h10;
   task automatic put(input logic [4:0] v);
      @(posedge I_CORE_CLK);
      {I_POWER_DOWN_N_DRIVEN, I_POWER_DOWN_N, I_SELF_TEST_ENABLE_PIN, I_PIN4, I_PIN16} <= v;
   endtask : put
endmodule : pdstc_host

// ==== tb/pdstc_top_bench.sv ====
// bench for pdstc_top with host model and checker
// 200 MHz clock; register port driven by nba
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
   $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module pdstc_top_bench;
   import pdstc_pkg::*;
   logic I_CORE_CLK = 0, I_RST = 1, I_WR = 0, I_RD = 0, I_SPI_SELECT_DRIVE = 0;
   logic I_POWER_DOWN_N, I_POWER_DOWN_N_DRIVEN, I_SELF_TEST_ENABLE_PIN, I_PIN4, I_PIN16;
   logic [3:0] I_ADDR = 4'h0;
   logic [31:0] I_WDATA = 32'h0, O_RDATA;
   logic O_PIN4, O_PIN4_OE, O_PIN16, O_PIN16_OE, O_DEVICE_ENABLED, O_CORE_RESET, O_PLL_RUN;
   logic O_CMOS_OE, O_SELF_TEST_ON, O_SELF_TEST_CLK_SEL, O_INTERRUPT_IN, O_SPI_SELECT;
   logic O_FAST_GPIO_3_IN;
   int n_fail = 0, checked = 0, cyc = 0;
   always #2.5 I_CORE_CLK = ~I_CORE_CLK;
   pdstc_host i_host (.*);
   pdstc_top i_dut (.*);
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge I_CORE_CLK);
      I_ADDR <= a;
      I_WDATA <= d;
      I_WR <= 1'b1;
      @(posedge I_CORE_CLK);
      I_WR <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [3:0] a, input logic [31:0] e);
      @(posedge I_CORE_CLK);
      I_ADDR <= a;
      I_RD <= 1'b1;
      @(posedge I_CORE_CLK);
      I_RD <= 1'b0;
      #1 `CHK(O_RDATA, e)
   endtask : rreg
   task automatic setw(input logic [4:0] v);
      i_host.put(v);
      repeat (4) @(posedge I_CORE_CLK);
      #1;
   endtask : setw
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   // cut a hang short
   always @(posedge I_CORE_CLK) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         tally_and_finish;
      end
   end
   // main sequence
   initial begin
      repeat (2) @(posedge I_CORE_CLK);
      I_RST <= 1'b0;
      wreg(PDSTC_ADDR_CTRL, 32'h1F);
      rreg(PDSTC_ADDR_CTRL, PDSTC_ZERO32);
      rreg(PDSTC_ADDR_STATUS, 32'h1);
      `CHK({O_CMOS_OE, O_PLL_RUN}, 2'h0)
      setw(5'h1E);
      `CHK({O_DEVICE_ENABLED, O_CORE_RESET, O_PLL_RUN}, 3'h5)
      rreg(PDSTC_ADDR_STATUS, 32'h4);
      `CHK({O_SELF_TEST_ON, O_INTERRUPT_IN, O_SELF_TEST_CLK_SEL}, 3'h6)
      wreg(PDSTC_ADDR_CTRL, 32'h3);
      setw(5'h1B);
      `CHK({O_SELF_TEST_ON, O_SELF_TEST_CLK_SEL, O_INTERRUPT_IN}, 3'h2)
      `CHK({O_FAST_GPIO_3_IN, O_SPI_SELECT}, 2'h2)
      wreg(PDSTC_ADDR_CTRL, 32'h0);
      setw(5'h19);
      `CHK({O_SPI_SELECT, O_SELF_TEST_CLK_SEL}, 2'h2)
      rreg(4'hF, PDSTC_ZERO32);
      wreg(PDSTC_ADDR_CTRL, 32'h1F);
      setw(5'h19);
      `CHK({O_PIN16_OE, O_PIN16, O_FAST_GPIO_3_IN}, 3'h7)
      setw(5'h08);
      `CHK({O_DEVICE_ENABLED, O_CMOS_OE, O_PIN16_OE}, 3'h0)
      `CHK({O_PIN4_OE, O_PIN4}, 2'h2)
      rreg(PDSTC_ADDR_STATUS, 32'h1);
      setw(5'h18);
      rreg(PDSTC_ADDR_CTRL, PDSTC_ZERO32);
      `CHK(O_PIN4_OE, 1'h0)
      tally_and_finish;
   end
endmodule : pdstc_top_bench
bind pdstc_top pdstc_chk i_chk (.*);
